// ==== rtl/mcom_pkg.sv ====
// Purpose: Constants for the coil output map block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Coil index is coil number minus one
package mcom_pkg;
  localparam int unsigned COILS     = 128;
  localparam logic [7:0]  ADR_ADDR  = 8'h00;
  localparam logic [7:0]  ADR_QTY   = 8'h04;
  localparam logic [7:0]  ADR_CMD   = 8'h08;
  localparam logic [7:0]  ADR_STAT  = 8'h0C;
  localparam logic [7:0]  ADR_CFG   = 8'h10;
  localparam logic [7:0]  ADR_DATA  = 8'h20;
  localparam logic [7:0]  FN_READ   = 8'h01;
  localparam logic [7:0]  FN_SINGLE = 8'h05;
  localparam logic [7:0]  FN_MULTI  = 8'h0F;
  localparam logic [7:0]  EX_NONE   = 8'h00;
  localparam logic [7:0]  EX_FUNC   = 8'h01;
  localparam logic [7:0]  EX_ADDR   = 8'h02;
  localparam logic [7:0]  EX_VALUE  = 8'h03;
  localparam logic [15:0] VAL_ON    = 16'hFF00;
  localparam logic [15:0] VAL_OFF   = 16'h0000;
  localparam logic [16:0] COIL_LAST = 17'h00080;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_DONE   = 1;
  localparam int unsigned ST_EXC    = 8;
  localparam int unsigned CF_SLOT   = 0;
  localparam int unsigned CF_EXP1   = 16;
  localparam int unsigned CF_EXP2   = 17;
  localparam int unsigned CF_SETPT  = 18;
  localparam logic [18:0] CFG_RST   = 19'h00000;
  typedef enum logic [1:0] {
    MCOM_IDLE = 2'b01,
    MCOM_EXEC = 2'b10
  } mcom_st_t;
endpackage : mcom_pkg

// ==== rtl/mcom_req_check.sv ====
// Purpose: Validate one coil request and give its exception code
// Assumes: Inputs stable while the request executes
// Notes: Pure combinational
`timescale 1ns/10ps
`default_nettype none
module mcom_req_check
  import mcom_pkg::*;
(
  input  wire logic [7:0]  func,
  input  wire logic [15:0] frame_addr,
  input  wire logic [15:0] qty,
  output logic      [7:0]  exc
);
  logic [16:0] coil_num;
  logic [16:0] last_num;
  logic        func_ok;
  logic        qty_ok;
  logic        val_ok;
  logic        addr_ok;

  // Coil number is frame address plus one
  assign coil_num = {1'b0, frame_addr} + 17'h00001;
  assign last_num = {1'b0, frame_addr} + {1'b0, qty};
  assign func_ok  = (func == FN_READ) || (func == FN_SINGLE) || (func == FN_MULTI);
  assign qty_ok   = (qty != 16'h0000) && (qty <= COIL_LAST[15:0]);
  assign val_ok   = (qty == VAL_ON) || (qty == VAL_OFF);
  // Any coil past the last one is refused
  assign addr_ok  = (func == FN_SINGLE) ? (coil_num <= COIL_LAST)
                                        : (last_num <= COIL_LAST);

  assign exc = !func_ok                       ? EX_FUNC  :
               (func == FN_SINGLE && !val_ok) ? EX_VALUE :
               (func != FN_SINGLE && !qty_ok) ? EX_VALUE :
               !addr_ok                       ? EX_ADDR  : EX_NONE;
endmodule : mcom_req_check
`default_nettype wire

// ==== rtl/mcom_relay_map.sv ====
// Purpose: Route coil bits onto relay outputs by fitted hardware
// Assumes: Configuration from software register
// Notes: Outputs registered, one cycle behind coils
`timescale 1ns/10ps
`default_nettype none
module mcom_relay_map
  import mcom_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [COILS-1:0]  coils,
  input  wire logic [18:0]       cfg,
  output logic                   onboard_relay_first,
  output logic                   onboard_relay_second,
  output logic      [13:0]       slot_relay,
  output logic      [15:0]       exp1_relay,
  output logic      [15:0]       exp2_relay,
  output logic      [15:0]       setpoint_relay_output
);
  logic        exp2_on;
  logic [15:0] exp1_mask;
  logic [15:0] exp2_mask;
  logic [15:0] setpt_mask;

  assign exp2_on    = cfg[CF_EXP1] && cfg[CF_EXP2];
  assign exp1_mask  = {16{cfg[CF_EXP1]}};
  assign exp2_mask  = {16{exp2_on}};
  assign setpt_mask = {16{cfg[CF_SETPT]}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      onboard_relay_first   <= 1'b0;
      onboard_relay_second  <= 1'b0;
      slot_relay            <= 14'h0000;
      exp1_relay            <= 16'h0000;
      exp2_relay            <= 16'h0000;
      setpoint_relay_output <= 16'h0000;
    end else begin
      onboard_relay_first   <= coils[0];
      onboard_relay_second  <= coils[1];
      slot_relay            <= coils[15:2] & cfg[CF_SLOT +: 14];
      exp1_relay            <= coils[31:16] & exp1_mask;
      exp2_relay            <= coils[47:32] & exp2_mask;
      setpoint_relay_output <= coils[127:112] & setpt_mask;
    end
  end
endmodule : mcom_relay_map
`default_nettype wire

// ==== rtl/mcom_coil_map.sv ====
// Purpose: Coil output map with Wishbone command port
// Assumes: Classic Wishbone, ack one cycle after request
// Notes: Coils 49-112 are flags and drive no pin
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module mcom_coil_map
  import mcom_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             onboard_relay_first,
  output logic             onboard_relay_second,
  output logic      [13:0] slot_relay,
  output logic      [15:0] exp1_relay,
  output logic      [15:0] exp2_relay,
  output logic      [15:0] setpoint_relay_output
);
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [COILS-1:0] qmask(input logic [15:0] q);
    logic [COILS-1:0] m;
    m = (q >= COIL_LAST[15:0]) ? {COILS{1'b1}}
                               : ((128'h1 << q[6:0]) - 128'h1);
    return m;
  endfunction : qmask

  mcom_st_t          state;
  mcom_st_t          next_state;
  logic [COILS-1:0]  coils;
  logic [COILS-1:0]  next_coils;
  logic [COILS-1:0]  data;
  logic [15:0]       req_addr;
  logic [15:0]       req_qty;
  logic [7:0]        req_func;
  logic [7:0]        exc_code;
  logic              done;
  logic [18:0]       cfg;
  logic [7:0]        chk_exc;

  logic              req;
  logic              wr;
  logic              hit_addr;
  logic              hit_qty;
  logic              hit_cmd;
  logic              hit_stat;
  logic              hit_cfg;
  logic              hit_data;
  logic [1:0]        dword;
  logic              launch;
  logic              exec;
  logic              exec_ok;
  logic [6:0]        idx;
  logic [COILS-1:0]  mask;
  logic [COILS-1:0]  rd_result;
  logic [31:0]       rd_mux;
  logic [31:0]       stat_word;
  logic              clr_done;
  logic [31:0]       wr_word;

  // Bus decode
  assign req      = wb_cyc_i && wb_stb_i;
  assign wr       = req && wb_we_i && wb_ack_o;
  assign hit_addr = (wb_adr_i == ADR_ADDR);
  assign hit_qty  = (wb_adr_i == ADR_QTY);
  assign hit_cmd  = (wb_adr_i == ADR_CMD);
  assign hit_stat = (wb_adr_i == ADR_STAT);
  assign hit_cfg  = (wb_adr_i == ADR_CFG);
  assign hit_data = (wb_adr_i[7:4] == ADR_DATA[7:4]) && (wb_adr_i[1:0] == 2'b00);
  assign dword    = wb_adr_i[3:2];
  assign stat_word = {16'h0000, exc_code, 6'h00, done, exec};
  assign rd_mux   = hit_addr ? {16'h0000, req_addr} :
                    hit_qty  ? {16'h0000, req_qty} :
                    hit_cmd  ? {24'h000000, req_func} :
                    hit_stat ? stat_word :
                    hit_cfg  ? {13'h0000, cfg} :
                    hit_data ? data[dword*32 +: 32] : 32'h00000000;

  // Request control
  assign launch   = wr && hit_cmd && wb_sel_i[0] && (state == MCOM_IDLE);
  assign exec     = (state == MCOM_EXEC);
  assign exec_ok  = exec && (chk_exc == EX_NONE);
  assign clr_done = wr && hit_stat && wb_sel_i[0] && wb_dat_i[ST_DONE];
  // Current register word with the written bytes merged in
  assign wr_word  = merge(rd_mux, wb_dat_i, wb_sel_i);
  assign idx      = req_addr[6:0];
  assign mask     = qmask(req_qty);
  assign rd_result = (coils >> idx) & mask;

  always_comb begin
    next_coils = coils;
    if (exec_ok) begin
      case (req_func)
        FN_SINGLE: next_coils[idx] = (req_qty == VAL_ON);
        FN_MULTI:  next_coils = (coils & ~(mask << idx)) | ((data & mask) << idx);
        default:   next_coils = coils;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      MCOM_IDLE: if (launch) begin
        next_state = MCOM_EXEC;
      end
      MCOM_EXEC: next_state = MCOM_IDLE;
      default:   next_state = MCOM_IDLE;
    endcase
  end

  mcom_req_check u_check (
    .func       (req_func),
    .frame_addr (req_addr),
    .qty        (req_qty),
    .exc        (chk_exc)
  );

  mcom_relay_map u_map (
    .clk                   (clk),
    .nrst                  (nrst),
    .coils                 (coils),
    .cfg                   (cfg),
    .onboard_relay_first   (onboard_relay_first),
    .onboard_relay_second  (onboard_relay_second),
    .slot_relay            (slot_relay),
    .exp1_relay            (exp1_relay),
    .exp2_relay            (exp2_relay),
    .setpoint_relay_output (setpoint_relay_output)
  );

  // Bus answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // Request registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_addr <= 16'h0000;
      req_qty  <= 16'h0000;
      req_func <= 8'h00;
      cfg      <= CFG_RST;
    end else if (wr && !exec) begin
      if (hit_addr) begin
        req_addr <= wr_word[15:0];
      end else if (hit_qty) begin
        req_qty <= wr_word[15:0];
      end else if (hit_cmd && wb_sel_i[0]) begin
        req_func <= wb_dat_i[7:0];
      end else if (hit_cfg) begin
        cfg <= wr_word[18:0];
      end
    end
  end

  // Data buffer, coils, status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state    <= MCOM_IDLE;
      coils    <= {COILS{1'b0}};
      data     <= {COILS{1'b0}};
      exc_code <= EX_NONE;
      done     <= 1'b0;
    end else begin
      state <= next_state;
      coils <= next_coils;
      if (exec_ok && req_func == FN_READ) begin
        data <= rd_result;
      end else if (wr && hit_data && !exec) begin
        data[dword*32 +: 32] <= merge(data[dword*32 +: 32], wb_dat_i, wb_sel_i);
      end
      if (exec) begin
        exc_code <= chk_exc;
        done     <= 1'b1;
      end else if (clr_done) begin
        done <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_launch;
    launch;
  endsequence

  sequence s_exec_done;
    exec ##1 (done && !exec);
  endsequence

  read_result_a: assert property (
    exec_ok && req_func == FN_READ |=> data[0] == $past(coils[idx]))
    else $error("read result wrong");

  single_force_a: assert property (
    exec_ok && req_func == FN_SINGLE
      |=> coils[$past(idx)] == ($past(req_qty) == VAL_ON))
    else $error("single force wrong");

  multi_force_a: assert property (
    exec_ok && req_func == FN_MULTI |=> coils[$past(idx)] == $past(data[0]))
    else $error("multi force wrong");

  frame_offset_a: assert property (
    exec && req_func == FN_SINGLE && req_addr == 16'h007F && req_qty == VAL_ON
      |=> coils[127] && exc_code == EX_NONE)
    else $error("last coil not reached");

  onboard_a: assert property (
    ##1 onboard_relay_first == $past(coils[0]) && onboard_relay_second == $past(coils[1]))
    else $error("onboard relay wrong");

  slot_a: assert property (
    ##1 slot_relay == ($past(coils[15:2]) & $past(cfg[CF_SLOT +: 14])))
    else $error("slot relay wrong");

  exp_plain_a: assert property (
    !cfg[CF_EXP1] |=> exp1_relay == 16'h0000 && exp2_relay == 16'h0000)
    else $error("plain module driven while absent");

  exp_second_a: assert property (
    cfg[CF_EXP1] && cfg[CF_EXP2] |=> exp2_relay == $past(coils[47:32]))
    else $error("second module relay wrong");

  flag_hold_a: assert property (
    !exec |=> $stable(coils[111:48]))
    else $error("flags changed without request");

  setpoint_a: assert property (
    ##1 setpoint_relay_output == ($past(coils[127:112]) & {16{$past(cfg[CF_SETPT])}}))
    else $error("setpoint relay wrong");

  reject_a: assert property (
    exec && chk_exc != EX_NONE |=> $stable(coils) && exc_code != EX_NONE && done)
    else $error("rejected request changed coils");

  launch_done_a: assert property (
    s_launch |=> s_exec_done)
    else $error("request did not complete");

  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  answer_once_a: assert property (
    req && !wb_ack_o |=> s_answer)
    else $error("ack not a single pulse");

  ack_needs_req_a: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without request");

  busy_hold_a: assert property (
    exec |=> !exec)
    else $error("exec longer than one cycle");

  cfg_busy_a: assert property (
    exec |=> $stable(cfg) && $stable(req_func))
    else $error("register written while busy");

  read_tail_a: assert property (
    exec_ok && req_func == FN_READ && req_qty < COIL_LAST[15:0] |=> !data[127])
    else $error("read bits past quantity not zero");

  single_only_a: assert property (
    exec_ok && req_func == FN_SINGLE && idx != 7'h00 |=> coils[0] == $past(coils[0]))
    else $error("single force touched other coil");

  multi_outside_a: assert property (
    exec_ok && req_func == FN_MULTI && idx != 7'h00 |=> coils[0] == $past(coils[0]))
    else $error("multi force touched coil below range");

  done_sticky_a: assert property (
    done && !exec && !clr_done |=> done)
    else $error("done dropped without clear");

  exp_first_a: assert property (
    cfg[CF_EXP1] |=> exp1_relay == $past(coils[31:16]))
    else $error("first module relay wrong");

  fn_refused_a: assert property (
    exec && chk_exc == EX_FUNC |=> exc_code == EX_FUNC && $stable(coils))
    else $error("bad function not refused");
endmodule : mcom_coil_map
`default_nettype wire

// ==== tb/mcom_master_model.sv ====
// Purpose: Master side of the coil link, coil number to frame address
// Assumes: Coil numbers start at one
// Notes: Combinational, used by the bench to build requests
`timescale 1ns/10ps
`default_nettype none
module mcom_master_model (
  input  wire logic [15:0] coil_no,
  output logic      [15:0] frame_addr
);
  assign frame_addr = coil_no - 16'h0001;
endmodule : mcom_master_model
`default_nettype wire

// ==== tb/tb_modbus_coil_output_map.sv ====
// Purpose: Self-checking bench for the coil output map
// Assumes: Wishbone master in the bench, ack sampled at rising edge
// Notes: Each scenario is its own task
`timescale 1ns/10ps
`default_nettype none
module tb_modbus_coil_output_map;
  import mcom_pkg::*;
  logic        clk, nrst, cyc, stb, we, ack, ob1, ob2;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, q;
  logic [13:0] slot;
  logic [15:0] e1, e2, sp, coil_no, frame_addr;
  logic [45:0] p;
  int          n_errors, checks_done;

  mcom_master_model mm_u (.coil_no(coil_no), .frame_addr(frame_addr));
  mcom_coil_map dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .onboard_relay_first(ob1), .onboard_relay_second(ob2),
    .slot_relay(slot), .exp1_relay(e1), .exp2_relay(e2), .setpoint_relay_output(sp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [7:0] fn, input logic [15:0] coil, input logic [15:0] n,
                     input logic [7:0] ex);
    coil_no = coil;
    @(posedge clk);
    wb(1'b1, ADR_ADDR, {16'h0000, frame_addr});
    wb(1'b1, ADR_QTY, {16'h0000, n});
    wb(1'b1, ADR_CMD, {24'h000000, fn});
    wb(1'b0, ADR_STAT, 32'h00000000);
    chk("status", {16'h0000, ex, 8'h02}, q & 32'h0000FF03);
    wb(1'b1, ADR_STAT, 32'h00000002);
  endtask : cmd

  task automatic t_single();
    cmd(FN_SINGLE, 16'h0001, VAL_ON, EX_NONE);
    cmd(FN_SINGLE, 16'h0002, VAL_ON, EX_NONE);
    cmd(FN_SINGLE, 16'h0001, VAL_OFF, EX_NONE);
    cmd(FN_SINGLE, 16'h0002, 16'h1234, EX_VALUE);
    chk("relay_pair", 32'h00000002, {30'h0, ob2, ob1});
    cmd(FN_READ, 16'h0001, 16'h0002, EX_NONE);
    wb(1'b0, ADR_DATA, 32'h00000000);
    chk("read_pair", 32'h00000002, q);
    cmd(8'h03, 16'h0001, 16'h0001, EX_FUNC);
    cmd(FN_MULTI, 16'h0001, 16'h0000, EX_VALUE);
  endtask : t_single

  task automatic t_multi();
    wb(1'b1, ADR_CFG, 32'h00010F0F);
    wb(1'b1, ADR_DATA, p[31:0]);
    wb(1'b1, ADR_DATA + 8'h04, {18'h0, p[45:32]});
    cmd(FN_MULTI, 16'h0003, 16'd46, EX_NONE);
    chk("slot", {18'h0, p[13:0] & 14'h0F0F}, {18'h0, slot});
    chk("exp1", {16'h0, p[29:14]}, {16'h0, e1});
    chk("exp2_off", 32'h0, {16'h0, e2});
    wb(1'b1, ADR_CFG, 32'h00073FFF);
    wb(1'b0, 8'h30, 32'h00000000);
    chk("unmapped", 32'h0, q);
    chk("slot_all", {18'h0, p[13:0]}, {18'h0, slot});
    chk("exp2", {16'h0, p[45:30]}, {16'h0, e2});
  endtask : t_multi

  task automatic t_setpt();
    wb(1'b1, ADR_DATA, 32'h0000C3A5);
    cmd(FN_MULTI, 16'd113, 16'd16, EX_NONE);
    chk("setpoint", 32'h0000C3A5, {16'h0, sp});
    cmd(FN_SINGLE, 16'd129, VAL_ON, EX_ADDR);
    cmd(FN_MULTI, 16'd121, 16'd9, EX_ADDR);
    cmd(FN_SINGLE, 16'h0080, VAL_ON, EX_NONE);
    chk("setpoint_kept", 32'h0000C3A5, {16'h0, sp});
  endtask : t_setpt

  task automatic t_flags();
    wb(1'b1, ADR_DATA, 32'h89ABCDEF);
    wb(1'b1, ADR_DATA + 8'h04, 32'h01234567);
    cmd(FN_MULTI, 16'd49, 16'd64, EX_NONE);
    wb(1'b1, ADR_DATA, 32'h00000000);
    wb(1'b1, ADR_DATA + 8'h04, 32'h00000000);
    cmd(FN_READ, 16'd49, 16'd64, EX_NONE);
    wb(1'b0, ADR_DATA, 32'h00000000);
    chk("flags_lo", 32'h89ABCDEF, q);
    wb(1'b0, ADR_DATA + 8'h04, 32'h00000000);
    chk("flags_hi", 32'h01234567, q);
    cmd(FN_READ, 16'd48, 16'd2, EX_NONE);
    wb(1'b0, ADR_DATA, 32'h00000000);
    chk("edge_read", {30'h0, 1'b1, p[45]}, q);
  endtask : t_flags

  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
    coil_no = 16'h0001;
    p = 46'h2A5C3F0F1E2D;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_single();
    t_multi();
    t_setpt();
    t_flags();
    wrap_up();
  end
endmodule : tb_modbus_coil_output_map
`default_nettype wire
